//--- design/zcal_timer.sv
`timescale 1ns/100ps
module zcal_timer #(
  parameter int MOD_CLKS = zcal_pkg::MOD_CYCLE_CLKS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Sequencer side
  zcal_tmr_if.tmr  tif
);
  localparam int DW = $clog2(MOD_CLKS);

  logic [DW-1:0] div;
  logic [5:0]    periods;
  logic [5:0]    goal;

  // ==========================================================
  // Modulator cycle divider, free running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div <= '0;
    end else if (tif.ce) begin
      div <= (div == DW'(MOD_CLKS - 1)) ? '0 : div + 1'b1;
    end
  end
  assign tif.mod_tick = tif.ce && (div == DW'(MOD_CLKS - 1));

  // ==========================================================
  // Output-rate period counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periods     <= '0;
      goal        <= '0;
      tif.running <= 1'b0;
    end else if (tif.ce) begin
      if (tif.abort) begin
        tif.running <= 1'b0;
      end else if (tif.start) begin
        periods     <= '0;
        goal        <= tif.target;
        tif.running <= 1'b1;
      end else if (tif.running && tif.rate_tick) begin
        periods <= periods + 1'b1;
        if (periods + 1'b1 == goal) begin
          tif.running <= 1'b0;
        end
      end
    end
  end

  // One-cycle strobes on the period that closes each half
  assign tif.done = tif.ce && tif.running && !tif.abort && tif.rate_tick
                    && (periods + 1'b1 == goal);
  assign tif.half = tif.ce && tif.running && !tif.abort && tif.rate_tick
                    && (periods + 1'b1 == {1'b0, goal[5:1]});
endmodule

//--- design/zcal_top.sv
// The register addresses and the AHB-Lite slave port were decided locally.
`timescale 1ns/100ps
// Overview of operation
// - Mode 100 starts internal zero-scale calibration
// - Unipolar internal zero shorts inputs together
// - Calibration uses gain from range field
// - Internal calibrations force dc excitation
// - Zero-scale lasts 22 chopped, 24 unchopped
// - Internal full-scale lasts 44 or 48 periods
// - Mode field returns to idle at completion
// - Ready high during calibration, low after
// - Zero-scale only updates offset, no result
// - Ready may lag one modulator cycle
// - Bipolar zero input maps to 800000 hex
// - Mode 101 starts internal full-scale calibration
// - Full-scale runs two steps, rewriting offset
// - Mode 110 starts system zero-scale calibration
// - System zero uses selected excitation
// - Bipolar system zero is transfer midpoint
// - Coefficients are 24-bit, host readable, writable
// - Offset subtracted before gain multiply
module zcal_top #(
  parameter int MOD_CLKS = zcal_pkg::MOD_CYCLE_CLKS
) (
  // Clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Filter result stream, one strobe per output-rate period
  input  wire logic [23:0] filt_data,
  input  wire logic        filt_valid,
  // Front-end controls
  output logic      [1:0]  pga_gain,
  output logic             analog_input_pair,
  output logic             alternating_excitation_select,
  output logic             input_short,
  output logic             fs_ref_select,
  // Ready line
  output logic             ready_n
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_ZERO  = 4'b0100,
    ST_FULL  = 4'b1000
  } zcal_state_t;

  zcal_tmr_if tif ();

  zcal_state_t state;
  logic [9:0]  mode;
  logic [2:0]  cal_op;
  logic        cal_chan;
  logic [23:0] offs [2];
  logic [23:0] gain [2];
  logic [23:0] data;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  dp_addr;
  logic        mode_wr;
  logic [2:0]  wr_op;
  logic        wr_is_cal;
  logic        conv_mode;
  logic        cal_busy;
  logic        cal_live;
  logic        conv_load;
  logic [31:0] status_word;
  logic signed [25:0] diff;
  logic signed [50:0] prod;
  logic [23:0] next_data;

  // ==========================================================
  // AHB-Lite slave: zero-wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_en   <= 1'b0;
      rd_en   <= 1'b0;
      dp_addr <= '0;
    end else if (ce && hready) begin
      wr_en   <= hsel && htrans[1] && hwrite;
      rd_en   <= hsel && htrans[1] && !hwrite;
      dp_addr <= haddr;
    end
  end

  assign mode_wr   = ce && wr_en && (dp_addr == zcal_pkg::ADDR_MODE);
  assign wr_op     = hwdata[zcal_pkg::MODE_OP_LSB +: 3];
  assign wr_is_cal = (wr_op == zcal_pkg::OP_INT_ZS) || (wr_op == zcal_pkg::OP_INT_FS)
                     || (wr_op == zcal_pkg::OP_SYS_ZS);
  assign conv_mode = (mode[2:0] == zcal_pkg::OP_CONT) || (mode[2:0] == zcal_pkg::OP_SINGLE);
  assign cal_busy  = (state != ST_IDLE);
  assign cal_live  = (state == ST_ZERO) || (state == ST_FULL);
  assign conv_load = ce && filt_valid && conv_mode && !cal_busy;

  // Status flags sit at their fixed positions; all other bits read zero
  always_comb begin
    status_word                         = 32'h0;
    status_word[zcal_pkg::STAT_READY_N] = ready_n;
    status_word[zcal_pkg::STAT_BUSY]    = cal_busy;
    status_word[zcal_pkg::STAT_STEP2]   = (state == ST_FULL);
  end

  always_comb begin
    hrdata = 32'h0;
    if (rd_en) begin
      unique case (dp_addr)
        zcal_pkg::ADDR_MODE:   hrdata = {22'h0, mode};
        zcal_pkg::ADDR_STATUS: hrdata = status_word;
        zcal_pkg::ADDR_OFFS0:  hrdata = {8'h0, offs[0]};
        zcal_pkg::ADDR_OFFS1:  hrdata = {8'h0, offs[1]};
        zcal_pkg::ADDR_GAIN0:  hrdata = {8'h0, gain[0]};
        zcal_pkg::ADDR_GAIN1:  hrdata = {8'h0, gain[1]};
        zcal_pkg::ADDR_DATA:   hrdata = {8'h0, data};
        default:               hrdata = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Mode register; a host write aborts the timer, so it wins over the hardware return to idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= zcal_pkg::MODE_RESET;
    end else if (ce) begin
      if (tif.done && state == ST_FULL || tif.done && state == ST_ZERO) begin
        mode[2:0] <= zcal_pkg::OP_IDLE;
      end else if (mode_wr) begin
        mode <= hwdata[9:0];
      end
    end
  end

  // ==========================================================
  // Sequencer: a command waits for the next modulator cycle
  assign tif.ce        = ce;
  assign tif.rate_tick = filt_valid;
  assign tif.abort     = mode_wr && cal_busy;
  assign tif.start     = ce && state == ST_WAIT && tif.mod_tick && !mode_wr;
  always_comb begin
    if (cal_op == zcal_pkg::OP_INT_FS) begin
      tif.target = mode[zcal_pkg::MODE_CHOP] ? zcal_pkg::FS_PERIODS_CHOP
                                             : zcal_pkg::FS_PERIODS_NOCHOP;
    end else begin
      tif.target = mode[zcal_pkg::MODE_CHOP] ? zcal_pkg::ZS_PERIODS_CHOP
                                             : zcal_pkg::ZS_PERIODS_NOCHOP;
    end
  end

  // Operation is latched with the write; a new mode write replaces it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_op <= zcal_pkg::OP_IDLE;
    end else if (mode_wr) begin
      cal_op <= wr_op;
    end
  end

  // Channel is frozen at the modulator boundary, not at the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_chan <= 1'b0;
    end else if (tif.start) begin
      cal_chan <= mode[zcal_pkg::MODE_CHAN];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
    end else if (ce) begin
      if (mode_wr) begin
        // A new mode write aborts any calibration in flight
        state <= wr_is_cal ? ST_WAIT : ST_IDLE;
      end else begin
        unique case (state)
          ST_IDLE: begin
            state <= ST_IDLE;
          end
          ST_WAIT: begin
            if (tif.mod_tick) begin
              state <= ST_ZERO;
            end
          end
          ST_ZERO: begin
            if (tif.done) begin
              state <= ST_IDLE;
            end else if (tif.half && cal_op == zcal_pkg::OP_INT_FS) begin
              state <= ST_FULL;
            end
          end
          ST_FULL: begin
            if (tif.done) begin
              state <= ST_IDLE;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  zcal_timer #(.MOD_CLKS(MOD_CLKS)) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tif     (tif)
  );

  // ==========================================================
  // Front-end steering
  always_comb begin
    pga_gain          = mode[zcal_pkg::MODE_RANGE_LSB +: 2];
    // While waiting for the boundary the latched channel is stale, so show the new one
    analog_input_pair = cal_live ? cal_chan : mode[zcal_pkg::MODE_CHAN];
    // Both internal calibrations see the shorted pair at the zero step, not at the full-scale step
    input_short       = cal_busy && cal_op != zcal_pkg::OP_SYS_ZS
                        && state != ST_FULL;
    fs_ref_select     = (state == ST_FULL);
    if (cal_busy && cal_op != zcal_pkg::OP_SYS_ZS) begin
      alternating_excitation_select = 1'b0;
    end else begin
      alternating_excitation_select = mode[zcal_pkg::MODE_AC];
    end
  end

  // ==========================================================
  // Coefficients: 24 bits per channel, calibration wins over host
  for (genvar c = 0; c < 2; c++) begin : g_coef
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        offs[c] <= zcal_pkg::OFFS_RESET;
        gain[c] <= zcal_pkg::GAIN_RESET;
      end else if (ce) begin
        if (cal_chan == 1'(c) && state == ST_ZERO && (tif.done || tif.half
            && cal_op == zcal_pkg::OP_INT_FS)) begin
          // The zero reading is the midpoint for bipolar ranges too
          offs[c] <= filt_data;
        end else if (wr_en && dp_addr == (zcal_pkg::ADDR_OFFS0 + 8'(4 * c))) begin
          offs[c] <= hwdata[23:0];
        end
        if (cal_chan == 1'(c) && state == ST_FULL && tif.done) begin
          gain[c] <= filt_data - offs[c];
        end else if (wr_en && dp_addr == (zcal_pkg::ADDR_GAIN0 + 8'(4 * c))) begin
          gain[c] <= hwdata[23:0];
        end
      end
    end
  end

  // ==========================================================
  // Result scaling; saturation is left to the filter headroom
  always_comb begin
    diff = $signed({2'b00, filt_data}) - $signed({2'b00, offs[mode[zcal_pkg::MODE_CHAN]]});
    prod = diff * $signed({2'b00, gain[mode[zcal_pkg::MODE_CHAN]]});
    next_data = 24'(prod >>> zcal_pkg::GAIN_SHIFT);
    if (mode[zcal_pkg::MODE_BIPOLAR]) begin
      next_data = next_data + zcal_pkg::BIPOLAR_MID;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data <= '0;
    end else if (conv_load) begin
      data <= next_data;
    end
  end

  // ==========================================================
  // Ready line: high while calibrating or after data read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_n <= 1'b1;
    end else if (ce) begin
      if (tif.done) begin
        ready_n <= 1'b0;
      end else if (tif.start) begin
        // Raised at the modulator boundary, so it may lag the write
        ready_n <= 1'b1;
      end else if (conv_load) begin
        ready_n <= 1'b0;
      end else if (rd_en && dp_addr == zcal_pkg::ADDR_DATA) begin
        ready_n <= 1'b1;
      end
    end
  end
endmodule

//--- pkg/zcal_pkg.sv
package zcal_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_OFFS0  = 8'h08;
  localparam logic [7:0] ADDR_OFFS1  = 8'h0c;
  localparam logic [7:0] ADDR_GAIN0  = 8'h10;
  localparam logic [7:0] ADDR_GAIN1  = 8'h14;
  localparam logic [7:0] ADDR_DATA   = 8'h18;

  // ==========================================================
  // Mode register fields
  localparam int MODE_OP_LSB    = 0;
  localparam int MODE_RANGE_LSB = 3;
  localparam int MODE_BIPOLAR   = 5;
  localparam int MODE_CHOP      = 6;
  localparam int MODE_AC        = 7;
  localparam int MODE_CHAN      = 8;

  // Status register fields
  localparam int STAT_READY_N = 0;
  localparam int STAT_BUSY    = 1;
  localparam int STAT_STEP2   = 2;

  // ==========================================================
  // Operating mode codes
  localparam logic [2:0] OP_IDLE    = 3'h0;
  localparam logic [2:0] OP_CONT    = 3'h1;
  localparam logic [2:0] OP_SINGLE  = 3'h2;
  localparam logic [2:0] OP_INT_ZS  = 3'h4;
  localparam logic [2:0] OP_INT_FS  = 3'h5;
  localparam logic [2:0] OP_SYS_ZS  = 3'h6;

  // ==========================================================
  // Timing, in output-rate periods and master clocks
  localparam logic [5:0] ZS_PERIODS_CHOP   = 6'd22;
  localparam logic [5:0] ZS_PERIODS_NOCHOP = 6'd24;
  localparam logic [5:0] FS_PERIODS_CHOP   = 6'd44;
  localparam logic [5:0] FS_PERIODS_NOCHOP = 6'd48;
  localparam int         MOD_CYCLE_CLKS    = 32;

  // ==========================================================
  // Coefficient and data layout
  localparam int          COEF_W       = 24;
  localparam int          GAIN_SHIFT   = 23;
  localparam logic [23:0] BIPOLAR_MID  = 24'h800000;
  localparam logic [23:0] OFFS_RESET   = 24'h800000;
  localparam logic [23:0] GAIN_RESET   = 24'h800000;
  localparam logic [9:0]  MODE_RESET   = 10'h000;
endpackage

//--- pkg/zcal_tmr_if.sv
`timescale 1ns/100ps
interface zcal_tmr_if;
  logic       ce;
  logic       start;
  logic       abort;
  logic [5:0] target;
  logic       rate_tick;
  logic       mod_tick;
  logic       half;
  logic       done;
  logic       running;

  modport ctrl (output ce, start, abort, target, rate_tick,
                input  mod_tick, half, done, running);
  modport tmr  (input  ce, start, abort, target, rate_tick,
                output mod_tick, half, done, running);
endinterface

//--- verif/test_zcal_top.sv
`timescale 1ns/100ps
module test_zcal_top;
  localparam int MODC = 4;
  localparam int PER  = 6;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        run;
  logic        fixd;
  logic        rdp;
  logic [1:0]  htrans;
  logic [7:0]  haddr;
  logic [31:0] hwdata;
  logic [31:0] lfsr;
  logic [23:0] din;
  logic [23:0] gexp [2];
  logic [23:0] fd [64];
  logic [31:0] exq [$];
  wire  [31:0] hrdata;
  wire  [23:0] filt_data;
  wire  [1:0]  pga_gain;
  wire         hready, hresp, filt_valid, aip, alt, ishort, fsref, ready_n;
  int          failures;
  int          comparisons;
  int          cyc;
  int          np;

  zcal_top #(.MOD_CLKS(MODC)) uut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .filt_data(filt_data), .filt_valid(filt_valid), .pga_gain(pga_gain),
    .analog_input_pair(aip), .alternating_excitation_select(alt), .input_short(ishort),
    .fs_ref_select(fsref), .ready_n(ready_n));
  zcal_filt_model #(.PER(PER)) prt (.hclk(hclk), .hresetn(hresetn), .run(run), .din(din),
    .filt_data(filt_data), .filt_valid(filt_valid));

  // ====
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Reads leave their expectation for the monitor
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    if (!w) begin
      exq.push_back(d);
    end
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : lfsr;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask

  task automatic cal(input logic [2:0] op, input logic chop, input logic ch);
    logic [9:0]  m;
    logic [23:0] oe;
    logic [23:0] ge;
    int          n;
    m = {1'b0, ch, lfsr[5], chop, lfsr[9], (op == 3'h5) ? 2'h3 : lfsr[1:0], op};
    n = (op == 3'h5) ? (chop ? 44 : 48) : (chop ? 22 : 24);
    bus(1'b1, zcal_pkg::ADDR_MODE, {22'h0, m});
    repeat (MODC + 2) @(posedge hclk);
    chk(ready_n, 1'b1);
    chk(pga_gain, m[4:3]);
    chk(aip, ch);
    chk(alt, (op == 3'h6) && m[7]);
    chk(ishort, op != 3'h6);
    np = 0;
    run <= 1'b1;
    for (int i = 0; i < 50 * PER && ready_n !== 1'b0; i++) @(posedge hclk);
    run <= 1'b0;
    chk(np, n);
    oe = (op == 3'h5) ? fd[n / 2 - 1] : fd[n - 1];
    ge = (op == 3'h5) ? fd[n - 1] - fd[n / 2 - 1] : gexp[ch];
    gexp[ch] = ge;
    bus(1'b0, zcal_pkg::ADDR_MODE, {22'h0, m[9:3], 3'h0});
    bus(1'b0, ch ? zcal_pkg::ADDR_OFFS1 : zcal_pkg::ADDR_OFFS0, {8'h0, oe});
    bus(1'b0, ch ? zcal_pkg::ADDR_GAIN1 : zcal_pkg::ADDR_GAIN0, {8'h0, ge});
  endtask

  // ====
  // Clock, monitor and hang guard
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    if (rdp) begin
      chk(hrdata, exq.pop_front());
    end
    rdp  <= hsel && htrans[1] && !hwrite && hready;
    lfsr <= lfsr_next(lfsr);
    din  <= fixd ? 24'h000100 : lfsr[23:0];
    if (filt_valid && ready_n === 1'b1) begin
      fd[np] <= filt_data;
      np     <= np + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  // ====
  // Main sequence
  initial begin
    logic [2:0] ops [6];
    ops         = '{3'h5, 3'h4, 3'h5, 3'h6, 3'h6, 3'h4};
    failures    = 0;
    comparisons = 0;
    cyc         = 0;
    np          = 0;
    hresetn     = 1'b0;
    hsel        = 1'b0;
    hwrite      = 1'b0;
    htrans      = 2'h0;
    haddr       = 8'h00;
    hwdata      = 32'h0;
    run         = 1'b0;
    fixd        = 1'b0;
    rdp         = 1'b0;
    lfsr        = 32'hdd50;
    din         = 24'h0;
    gexp[0]     = zcal_pkg::GAIN_RESET;
    gexp[1]     = zcal_pkg::GAIN_RESET;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // Each full-scale step is followed by a zero-scale on the same channel
    for (int i = 0; i < 6; i++) begin
      cal(ops[i], i[0] ^ i[1] ^ i[2], i[1]);
      $display("calibration test %0d done", i);
    end
    bus(1'b0, zcal_pkg::ADDR_DATA, 32'h00000000);
    fixd <= 1'b1;
    bus(1'b1, zcal_pkg::ADDR_OFFS0, 32'h00000010);
    bus(1'b1, zcal_pkg::ADDR_GAIN0, 32'h00400000);
    bus(1'b1, zcal_pkg::ADDR_DATA, 32'h00ffffff);
    bus(1'b0, zcal_pkg::ADDR_GAIN0, 32'h00400000);
    bus(1'b1, zcal_pkg::ADDR_MODE, 32'h00000021);
    run <= 1'b1;
    repeat (PER + 2) @(posedge hclk);
    run <= 1'b0;
    chk(ready_n, 1'b0);
    bus(1'b0, zcal_pkg::ADDR_DATA, 32'h00800078);
    bus(1'b0, zcal_pkg::ADDR_STATUS, 32'h00000001);
    bus(1'b0, 8'h1c, 32'h0);
    $display("conversion test done");
    finish_test();
  end
endmodule

//--- verif/zcal_filt_model.sv
`timescale 1ns/100ps
module zcal_filt_model #(
  parameter int PER = 6
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Result stream
  input  wire logic        run,
  input  wire logic [23:0] din,
  output logic      [23:0] filt_data,
  output logic             filt_valid
);
  int cnt;
  // ====
  // Data flips between strobes so a stale word never passes for fresh
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt        <= 0;
      filt_valid <= 1'b0;
      filt_data  <= 24'h000000;
    end else begin
      cnt        <= (cnt == PER - 1) ? 0 : cnt + 1;
      filt_valid <= run && (cnt == PER - 1);
      filt_data  <= (run && (cnt == PER - 1)) ? din : ~filt_data;
    end
  end
endmodule

//--- verif/zcal_top_sva.sv
`timescale 1ns/100ps
module zcal_top_sva #(
  parameter int MOD_CLKS = zcal_pkg::MOD_CYCLE_CLKS
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  // Bus
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Front end
  input wire logic        filt_valid,
  input wire logic [1:0]  pga_gain,
  input wire logic        analog_input_pair,
  input wire logic        alternating_excitation_select,
  input wire logic        input_short,
  input wire logic        fs_ref_select,
  input wire logic        ready_n
);
  localparam int RDY_MAX = MOD_CLKS + 2;
  logic       wdp;
  logic       rdp;
  logic       done_q;
  logic [9:0] mq;
  logic [5:0] pc;
  wire        take = hsel && htrans[1] && hready && ce && (haddr == zcal_pkg::ADDR_MODE);
  // ====
  // Shadow of the mode word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdp <= 1'b0;
      rdp <= 1'b0;
      mq  <= zcal_pkg::MODE_RESET;
    end else begin
      wdp <= take && hwrite;
      rdp <= take && !hwrite;
      if (wdp) begin
        mq <= hwdata[9:0];
      end
    end
  end
  // Counts only while ready is high, so strobes while idle with ready low never leak in
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc     <= 6'h00;
      done_q <= 1'b0;
    end else begin
      pc     <= !ready_n ? 6'h00 : pc + {5'h00, filt_valid};
      done_q <= !wdp && (done_q || ($fell(ready_n) && mq[2]));
    end
  end
  // ====
  // Properties
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not okay");
  property p_start; wdp && hwdata[2] && (hwdata[1:0] != 2'h3) |-> ##[1:RDY_MAX] ready_n; endproperty
  a_start: assert property (p_start) else $error("ready late at start");
  property p_zs_len; $fell(ready_n) && (mq[2:0] == 3'h4 || mq[2:0] == 3'h6)
    |-> pc == (mq[6] ? 6'd22 : 6'd24); endproperty
  a_zs_len: assert property (p_zs_len) else $error("zero-scale length");
  property p_fs_len; $fell(ready_n) && mq[2:0] == 3'h5 |-> pc == (mq[6] ? 6'd44 : 6'd48); endproperty
  a_fs_len: assert property (p_fs_len) else $error("full-scale length");
  property p_steps; $rose(fs_ref_select)
    |-> $past(filt_valid) && !input_short && pc == (mq[6] ? 6'd22 : 6'd24); endproperty
  a_steps: assert property (p_steps) else $error("second step misplaced");
  property p_idle; rdp && done_q |-> hrdata[2:0] == 3'h0; endproperty
  a_idle: assert property (p_idle) else $error("mode not idle");
  property p_dc; input_short || fs_ref_select |-> !alternating_excitation_select; endproperty
  a_dc: assert property (p_dc) else $error("ac during internal step");
  property p_front; input_short || fs_ref_select
    |-> pga_gain == mq[4:3] && analog_input_pair == mq[8]; endproperty
  a_front: assert property (p_front) else $error("gain or channel wrong");
  property p_sysac; mq[2:0] == 3'h6 |-> alternating_excitation_select == mq[7]; endproperty
  a_sysac: assert property (p_sysac) else $error("excitation wrong");
  property p_short; input_short |-> mq[2:1] == 2'b10 && !fs_ref_select; endproperty
  a_short: assert property (p_short) else $error("short outside internal");
  c_zs: cover property ($fell(ready_n) && mq[2:0] == 3'h4);
  c_fs: cover property ($rose(fs_ref_select));
  c_sys: cover property ($fell(ready_n) && mq[2:0] == 3'h6);
endmodule

bind zcal_top zcal_top_sva #(.MOD_CLKS(MOD_CLKS)) chk (.hclk, .hresetn, .ce, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .filt_valid, .pga_gain,
  .analog_input_pair, .alternating_excitation_select, .input_short, .fs_ref_select, .ready_n);
